// >>> pkg/spi_port_map.vh
// Purpose: register map, field positions and timing counts of the SPI port
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes: included by the port top module
// Summary of operation
// - Master starts transfers whenever software chooses
// - Master buffer write starts duplex byte
// - Output disabled master still receives bytes
// - Master rate osc/4, /16, /64, timer/2
// - MSB first; clock idles at polarity
// - Edge select set: data before edge
// - SPI modes map to polarity/edge bits
// - Sample phase bit picks input sample point
// - Slave shifts on external clock, flags
// - Select control: drive output only when low
// - Select high floats output two clocks later, after the sync
// - Select high resets port logic
// - Port reset clears bit counter
// - Output as input suppresses transmission
// - Master sleep freezes transfer, resumes
// - Slave completes bytes during sleep, wakes
// - Device reset disables port, aborts transfer
// - Control/status reset zero; buffer unaffected
// - Mode field encodings for master/slave
// - Busy buffer write ignored, collision flagged
// - Completed byte fills buffer, read clears
// - Unread buffer overwritten sets overflow
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH
`define ADDR_DATA_BUF 4'h0
`define ADDR_CONTROL 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_AUX 4'hc
`define CTL_COLL 7
`define CTL_OVF 6
`define CTL_EN 5
`define CTL_POL 4
`define STA_PHASE 7
`define STA_CKE 6
`define STA_FULL 0
`define AUX_IF 0
`define AUX_IE 1
`define AUX_SDO_IN 2
`define MODE_M4 4'h0
`define MODE_M16 4'h1
`define MODE_M64 4'h2
`define MODE_MTMR 4'h3
`define MODE_S_SEL 4'h4
`define MODE_S_NOSEL 4'h5
`define HALF_DIV4 8'h02
`define HALF_DIV16 8'h08
`define HALF_DIV64 8'h20
`define REG_RESET 8'h00
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// >>> logic/spi_port.v
// Purpose: SPI master/slave serial port with AXI4-Lite register access
// Assumes: pins synchronous to clk_sys in master mode; slave clock and select resynchronised, sdi not
// Notes: one system clock; slave clock must be slower than clk_sys/4
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_map.vh"
module spi_port (
   input wire clk_sys,
   input wire reset_n,
   input wire sleep_req,
   input wire timer_tick,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire sck_i,
   output reg sck_o,
   output wire sck_oe,
   input wire sdi,
   output reg sdo_o,
   output wire sdo_oe,
   input wire ss_n,
   output wire port_irq,
   output wire wake
);
   reg rst_a_q, rst_b_q;
   wire rst_n = rst_b_q;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_a_q <= 1'b0;
         rst_b_q <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_b_q <= rst_a_q;
      end
   end

   reg [7:0] ctl_q, sta_q, buf_q, shreg_q;
   reg irq_flag_q, irq_en_q, sdo_in_q;
   reg [3:0] bitcnt_q;
   reg busy_q, phase_q;
   reg [7:0] div_q;
   reg [2:0] sck_s_q, ss_s_q;
   wire en = ctl_q[`CTL_EN];
   wire clk_pol = ctl_q[`CTL_POL];
   wire cke = sta_q[`STA_CKE];
   wire sample_late = sta_q[`STA_PHASE];
   wire [3:0] mode = ctl_q[3:0];
   // Modes 0..3 master, 4/5 slave; others unsupported here
   wire is_master = en && (mode[3:2] == 2'b00);
   wire is_slave = en && (mode == `MODE_S_SEL || mode == `MODE_S_NOSEL);
   wire sel_ctl = mode == `MODE_S_SEL;
   // Two-flop synchronisers; third stage only for edges
   wire ss_sync = ss_s_q[1];
   wire sck_rise = sck_s_q[1] & ~sck_s_q[2];
   wire sck_fall = ~sck_s_q[1] & sck_s_q[2];
   wire ss_high = sel_ctl && ss_sync;
   wire slave_rst = is_slave && ss_high;

   // Leading edge is the one away from idle level
   wire lead_edge = clk_pol ? sck_fall : sck_rise;
   wire trail_edge = clk_pol ? sck_rise : sck_fall;
   wire s_sample = cke ? lead_edge : trail_edge;
   wire s_shift = cke ? trail_edge : lead_edge;

   // AXI write channel: accept address and data separately, write once both are held
   reg [3:0] awaddr_q;
   reg aw_got_q, w_got_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
   assign s_axi_wready = !w_got_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire wr_go = aw_got_q && w_got_q;
   wire rd_go = s_axi_arvalid && s_axi_arready;
   wire wr_buf = wr_go && awaddr_q[3:2] == 2'd0 && wstrb_q[0];
   wire wr_ctl = wr_go && awaddr_q[3:2] == 2'd1 && wstrb_q[0];
   wire wr_sta = wr_go && awaddr_q[3:2] == 2'd2 && wstrb_q[0];
   wire wr_aux = wr_go && awaddr_q[3:2] == 2'd3 && wstrb_q[0];
   wire rd_buf = rd_go && s_axi_araddr[3:2] == 2'd0;

   // Master bit clock: half-period ticks from divider or timer
   reg [7:0] half;
   always @* begin
      case (mode)
         `MODE_M4: half = `HALF_DIV4;
         `MODE_M16: half = `HALF_DIV16;
         `MODE_M64: half = `HALF_DIV64;
         default: half = 8'h01;
      endcase
   end
   wire tick_src = (mode == `MODE_MTMR) ? timer_tick : (div_q == half - 8'h01);
   // Sleep halts master clocks; state holds
   wire m_tick = is_master && busy_q && !sleep_req && tick_src;

   wire byte_done_m = m_tick && phase_q && bitcnt_q == 4'd7;
   wire done_s = is_slave && !slave_rst && s_sample && bitcnt_q == 4'd7;
   wire byte_done = byte_done_m || done_s;
   wire [7:0] rx_byte = {shreg_q[6:0], sdi};
   reg samp_q;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctl_q <= `REG_RESET;
         sta_q <= `REG_RESET;
         irq_flag_q <= 1'b0;
         irq_en_q <= 1'b0;
         sdo_in_q <= 1'b0;
         bitcnt_q <= 4'd0;
         busy_q <= 1'b0;
         phase_q <= 1'b0;
         div_q <= 8'h00;
         shreg_q <= 8'h00;
         samp_q <= 1'b0;
         sck_o <= 1'b0;
         sdo_o <= 1'b0;
         sck_s_q <= 3'b000;
         ss_s_q <= 3'b111;
      end else begin
         sck_s_q <= {sck_s_q[1:0], sck_i};
         ss_s_q <= {ss_s_q[1:0], ss_n};
         if (wr_ctl)
            ctl_q[5:0] <= wdata_q[5:0];
         if (wr_sta)
            sta_q[7:6] <= wdata_q[7:6];
         if (wr_aux) begin
            irq_en_q <= wdata_q[`AUX_IE];
            sdo_in_q <= wdata_q[`AUX_SDO_IN];
         end
         // Software may only clear sticky flags; a set in the same cycle wins
         if (wr_ctl && !wdata_q[`CTL_COLL])
            ctl_q[`CTL_COLL] <= 1'b0;
         if (wr_ctl && !wdata_q[`CTL_OVF])
            ctl_q[`CTL_OVF] <= 1'b0;
         if (wr_aux && !wdata_q[`AUX_IF])
            irq_flag_q <= 1'b0;
         if (rd_buf)
            sta_q[`STA_FULL] <= 1'b0;
         if (wr_buf && (busy_q || (is_slave && bitcnt_q != 4'd0)))
            ctl_q[`CTL_COLL] <= 1'b1;
         if (byte_done) begin
            if (sta_q[`STA_FULL] && !rd_buf)
               ctl_q[`CTL_OVF] <= 1'b1;
            sta_q[`STA_FULL] <= 1'b1;
            irq_flag_q <= 1'b1;
         end
         div_q <= (is_master && busy_q && !sleep_req) ?
            (tick_src ? 8'h00 : div_q + 8'h01) : div_q;
         if (!is_master || !busy_q)
            sck_o <= clk_pol;
         if (!en || slave_rst) begin
            bitcnt_q <= 4'd0;
            // Deselected slave may still preload its next reply
            if (slave_rst && wr_buf) begin
               shreg_q <= wdata_q[7:0];
               sdo_o <= wdata_q[7];
            end
            busy_q <= 1'b0;
            phase_q <= 1'b0;
            div_q <= 8'h00;
         end else if (is_master) begin
            if (wr_buf && !busy_q) begin
               busy_q <= 1'b1;
               shreg_q <= wdata_q[7:0];
               phase_q <= 1'b0;
               div_q <= 8'h00;
               bitcnt_q <= 4'd0;
               if (cke)
                  sdo_o <= wdata_q[7];
            end else if (m_tick) begin
               sck_o <= ~sck_o;
               phase_q <= ~phase_q;
               if (!phase_q) begin
                  // First half: leading edge
                  if (!cke)
                     sdo_o <= shreg_q[7];
                  if (!sample_late)
                     samp_q <= sdi;
               end else begin
                  // Second half: trailing edge; late sample when phase bit set
                  shreg_q <= {shreg_q[6:0], sample_late ? sdi : samp_q};
                  bitcnt_q <= bitcnt_q + 4'd1;
                  if (cke)
                     sdo_o <= shreg_q[6];
                  if (bitcnt_q == 4'd7) begin
                     busy_q <= 1'b0;
                     bitcnt_q <= 4'd0;
                     sck_o <= clk_pol;
                  end
               end
            end
         end else if (is_slave) begin
            if (wr_buf && bitcnt_q == 4'd0) begin
               shreg_q <= wdata_q[7:0];
               sdo_o <= wdata_q[7];
            end
            if (s_sample) begin
               shreg_q <= rx_byte;
               bitcnt_q <= (bitcnt_q == 4'd7) ? 4'd0 : bitcnt_q + 4'd1;
            end
            if (s_shift)
               sdo_o <= shreg_q[7];
         end
      end
   end

   // Receive buffer is not reset by design; holds last byte across resets
   always @(posedge clk_sys) begin
      if (byte_done_m)
         buf_q <= {shreg_q[6:0], sample_late ? sdi : samp_q};
      else if (done_s)
         buf_q <= rx_byte;
   end

   assign sck_oe = is_master;
   // Output floats when port off, disabled as input, or select high with select control in slave mode
   assign sdo_oe = en && !sdo_in_q && !(is_slave && ss_high);
   assign port_irq = irq_flag_q && irq_en_q;
   assign wake = port_irq;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `AXI_OKAY;
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_OKAY;
            case (s_axi_araddr[3:2])
               2'd0: s_axi_rdata <= {24'h0, buf_q};
               2'd1: s_axi_rdata <= {24'h0, ctl_q};
               2'd2: s_axi_rdata <= {24'h0, sta_q};
               default: s_axi_rdata <= {29'h0, sdo_in_q, irq_en_q, irq_flag_q};
            endcase
         end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule // spi_port
`default_nettype wire

// >>> sim/spi_peer_model.sv
// Purpose: far-side SPI peer that answers a master byte
// Assumes: edge select set, clock polarity given by inv
// Notes: load() presets the reply before each byte
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
   input wire logic sck,
   input wire logic inv,
   input wire logic mosi,
   output logic miso
);
   logic [7:0] sr = 8'h00;
   logic [7:0] rx = 8'h00;
   wire logic k = sck ^ inv;
   task load(input logic [7:0] b);
      sr = b;
      miso = b[7];
   endtask
   // Leading edge samples, MSB first
   always @(posedge k) rx <= {rx[6:0], mosi};
   // Inverted refill so a stale line never passes for data
   always @(negedge k) begin
      sr = {sr[6:0], ~sr[7]};
      miso = sr[7];
   end
endmodule // spi_peer_model
`default_nettype wire

// >>> sim/spi_port_asserts.sv
// Purpose: pin-level checks for spi_port
// Assumes: bound to every spi_port instance
// Notes: bus answers and serial clock pacing
`timescale 1ns/1ps
`default_nettype none
module spi_port_asserts (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic sleep_req,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sck_o,
   input wire logic sck_oe,
   input wire logic port_irq,
   input wire logic wake
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   AST_WAKE: assert property (wake == port_irq)
      else $error("wake mismatch");
   // Fastest divider still holds each level two cycles
   AST_SCK_HALF: assert property (sck_oe && $changed(sck_o) |=> $stable(sck_o))
      else $error("sck half too short");
   AST_SLEEP: assert property (sleep_req && $past(sleep_req) |-> $stable(sck_o))
      else $error("sck moved in sleep");
   AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid repeated");
   AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid repeated");
   AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("awready in answer");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready in answer");
   AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper rdata set");
endmodule // spi_port_asserts
bind spi_port spi_port_asserts asserts_i (.*);
`default_nettype wire

// >>> sim/spi_port_test.sv
// Purpose: self-checking bench for spi_port
// Assumes: AXI4-Lite master tasks, peer model as slave
// Notes: bready and rready stay high throughout
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_map.vh"
module spi_port_test;
   logic clk_sys = 1'h0, reset_n = 1'h0, sleep_req = 1'h0, timer_tick = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, sk_l = 1'h0;
   logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, sck_i = 1'h0, ss_n = 1'h1;
   logic sdi_s = 1'h0, slv = 1'h0, pol = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [2:0] tc = 3'h0;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic sck_o, sck_oe, sdo_o, sdo_oe, port_irq, wake, miso;
   wire logic sdi = slv ? sdi_s : miso;
   int miscompares = 0, checks_done = 0, cyc = 0, hc = 0, half = 0;
   spi_port dut (.*);
   // Floating data line reads high through its pull-up
   spi_peer_model peer (.sck(sck_o), .inv(pol), .mosi(sdo_oe ? sdo_o : 1'h1), .miso(miso));
   always #5 clk_sys = ~clk_sys;
   // Timer tick every 8 cycles; hc measures sck half periods
   always @(posedge clk_sys) begin
      tc <= tc + 3'h1;
      timer_tick <= (tc == 3'h7);
      sk_l <= sck_o;
      hc <= (sck_o != sk_l) ? 1 : hc + 1;
      if (sck_o != sk_l) half <= hc;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         miscompares++;
         give_verdict;
      end
   end
   task give_verdict;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      logic ta, tw, tb;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(negedge clk_sys);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid;
         @(posedge clk_sys);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
      end while (!tb);
   endtask
   task rc(input logic [3:0] a, input logic [31:0] e);
      logic ta, tr;
      logic [31:0] d;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(negedge clk_sys);
         ta = s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         @(posedge clk_sys);
         if (ta) s_axi_arvalid <= 1'h0;
      end while (!tr);
      chk($sformatf("reg %h", a), e, d);
   endtask
   // Master byte with a sleep spell in mid-transfer
   task xfer(input logic [7:0] tx, input logic [7:0] rx);
      peer.load(rx);
      wr(`ADDR_DATA_BUF, tx);
      repeat (6) @(posedge clk_sys);
      sleep_req <= 1'h1;
      repeat (40) @(posedge clk_sys);
      sleep_req <= 1'h0;
      while (port_irq !== 1'h1) @(posedge clk_sys);
   endtask
   task sbyte(input logic [7:0] b, input int n, output logic [7:0] q);
      ss_n <= 1'h0;
      for (int i = 7; i > 7 - n; i--) begin
         sdi_s <= b[i];
         repeat (10) @(posedge clk_sys);
         sck_i <= 1'h1;
         q[i] = sdo_o;
         chk("sdo drive", 1, sdo_oe);
         repeat (10) @(posedge clk_sys);
         sck_i <= 1'h0;
      end
      repeat (10) @(posedge clk_sys);
      ss_n <= 1'h1;
      sdi_s <= ~sdi_s;
   endtask
   task t_master;
      wr(`ADDR_STATUS, 8'h40);
      for (int m = 0; m < 4; m++) begin
         wr(`ADDR_CONTROL, 8'h00);
         pol <= m[0];
         wr(`ADDR_CONTROL, {3'h1, m[0], m[3:0]});
         wr(`ADDR_AUX, m == 2 ? 8'h06 : 8'h02);
         xfer({4'ha, m[3:0]}, {m[3:0], 4'h6});
         if (m != 2) chk("peer rx", {4'ha, m[3:0]}, peer.rx);
         if (m == 2) chk("sdo quiet", 0, sdo_oe);
         if (m == 2) chk("peer idle", 8'hff, peer.rx);
         chk("sck drive", 1, sck_oe);
         chk("half", m == 0 ? `HALF_DIV4 : m == 1 ? `HALF_DIV16 : m == 2 ? `HALF_DIV64 : 8'h08, half);
         chk("sck idle", m[0], sck_o);
         rc(`ADDR_DATA_BUF, {m[3:0], 4'h6});
         rc(`ADDR_STATUS, 8'h40);
         wr(`ADDR_AUX, 8'h02);
         chk("irq clear", 0, port_irq);
      end
   endtask
   task t_collide;
      wr(`ADDR_CONTROL, 8'h00);
      pol <= 1'h0;
      wr(`ADDR_CONTROL, 8'h20);
      peer.load(8'h11);
      wr(`ADDR_DATA_BUF, 8'h5a);
      wr(`ADDR_DATA_BUF, 8'hff);
      while (port_irq !== 1'h1) @(posedge clk_sys);
      chk("peer rx", 8'h5a, peer.rx);
      wr(`ADDR_AUX, 8'h02);
      xfer(8'h77, 8'h22);
      rc(`ADDR_CONTROL, 8'he0);
      rc(`ADDR_DATA_BUF, 8'h22);
      wr(`ADDR_AUX, 8'h02);
      wr(`ADDR_CONTROL, 8'h20);
      rc(`ADDR_CONTROL, 8'h20);
   endtask
   task t_slave;
      logic [7:0] q;
      wr(`ADDR_CONTROL, 8'h00);
      wr(`ADDR_CONTROL, 8'h24);
      slv <= 1'h1;
      sbyte(8'hc3, 3, q);
      repeat (6) @(posedge clk_sys);
      chk("sdo float", 0, sdo_oe);
      chk("sck input", 0, sck_oe);
      wr(`ADDR_DATA_BUF, 8'h5a);
      sbyte(8'h96, 8, q);
      repeat (6) @(posedge clk_sys);
      chk("slave irq", 1, port_irq);
      chk("slave tx", 8'h5a, q);
      rc(`ADDR_DATA_BUF, 8'h96);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'h1;
      repeat (3) @(posedge clk_sys);
      rc(`ADDR_CONTROL, 8'h00);
      rc(`ADDR_STATUS, 8'h00);
      t_master;
      t_collide;
      t_slave;
      give_verdict;
   end
endmodule // spi_port_test
`default_nettype wire
